// ---- rtl/srw_pkg.sv ----
// Package for the supervisory reset and watchdog block: timing constants,
// state encoding and the bundled input samples.
// Assumes a single 125 MHz reference clock.
package srw_pkg;

    localparam int unsigned CLK_HZ            = 125_000_000;
    localparam int unsigned CLK_PERIOD_NS     = 8;

    // Reset hold time in ms: least 140, nominal 200, most 400; nominal is used
    localparam int unsigned HOLD_TIME_MS      = 200;
    localparam int unsigned HOLD_CYCLES       = (CLK_HZ / 1000) * HOLD_TIME_MS;

    // Watchdog period in ms: least 1120, typical 1600, most 3200
    localparam int unsigned WD_PERIOD_MS      = 1600;
    localparam int unsigned WD_CYCLES         = (CLK_HZ / 1000) * WD_PERIOD_MS;

    // Pushbutton filter time in ns: low must persist this long to count
    localparam int unsigned PB_FILTER_NS      = 1000;
    localparam int unsigned PB_FILTER_CYCLES  =
        (PB_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest allowed pushbutton-to-output delay in ns
    localparam int unsigned PB_DELAY_MAX_NS   = 5000;

    localparam int unsigned CNT_W             = 32;
    localparam int unsigned PB_CNT_W          = 8;

    typedef enum logic [1:0] {
        SRW_ST_HOLD  = 2'b00,
        SRW_ST_RUN   = 2'b01,
        SRW_ST_PRESS = 2'b10
    } srw_state_t;

    // Synchronised pin samples
    typedef struct packed {
        logic pushbutton;
        logic strobe;
        logic undervolt;
    } srw_pins_t;

endpackage : srw_pkg

// ---- rtl/srw_supervisor.sv ----
// Supervisory reset generator with pushbutton input and watchdog timer.
// Assumes undervoltage arrives as a digital flag from an outside comparator
// and the strobe pad resolves the weak pull against any external driver.
//
// Overview of operation
// - Hold reset 200 ms after supply good.
// - Undervoltage asserts reset at once, holds it.
// - Hold period 140..400 ms, nominally 200.
// - Pushbutton low asserts reset.
// - Debounce pushbutton, stretch to hold period.
// - Pushbutton hold counts from its release.
// - Reset asserted within 5 us of press.
// - Reject ~100 ns pushbutton glitches.
// - No strobe edge in period forces reset.
// - Watchdog counts only while reset inactive.
// - Strobe edge restarts the full period.
// - After timeout, hold, release, restart watchdog.
// - Weak pull low 7/8, high 1/8 period.
// - Open strobe self-services; watchdog disabled.
module srw_supervisor
    import srw_pkg::*;
#(
    parameter bit          HAS_PUSHBUTTON = 1'b1,
    parameter bit          HAS_WATCHDOG   = 1'b1,
    parameter bit          HAS_RESET_HIGH = 1'b1,
    parameter int unsigned HOLD_CNT       = HOLD_CYCLES,
    parameter int unsigned WD_CNT         = WD_CYCLES
) (
    input  wire logic REF_CLK_IN,
    input  wire logic RSTN_IN,
    input  wire logic UNDERVOLT_IN,
    input  wire logic PUSHBUTTON_RESET_N_IN,
    input  wire logic WATCHDOG_STROBE_IN,
    output logic      WATCHDOG_STROBE_PULL_OUT,
    output logic      WATCHDOG_STROBE_PULL_OE_OUT,
    output logic      RESET_N_OUT,
    output logic      RESET_OUT
);

    localparam logic [CNT_W-1:0]    HOLD_LAST = CNT_W'(HOLD_CNT - 1);
    localparam logic [CNT_W-1:0]    WD_LAST   = CNT_W'(WD_CNT - 1);
    localparam logic [CNT_W-1:0]    PULL_HIGH = CNT_W'(WD_CNT - WD_CNT / 8);
    localparam logic [PB_CNT_W-1:0] PB_LAST   = PB_CNT_W'(PB_FILTER_CYCLES - 1);

    localparam int unsigned PIN_COUNT = $bits(srw_pins_t);

    // Flop reset values are the idle pin levels, so leaving reset
    // brings neither a false strobe edge nor a false press
    localparam srw_pins_t PINS_IDLE = '{
        pushbutton: 1'h1,
        strobe:     1'h0,
        undervolt:  1'h0
    };
    localparam logic [PIN_COUNT-1:0] PINS_IDLE_BITS = PINS_IDLE;

    srw_pins_t            pins_raw;
    logic [PIN_COUNT-1:0] pins_raw_bits;
    logic [PIN_COUNT-1:0] pins_meta;
    logic [PIN_COUNT-1:0] pins_sync;
    srw_pins_t            pins;
    logic                 strobe_prev;
    logic [PB_CNT_W-1:0]  pb_cnt;
    logic                 pb_pressed;
    srw_state_t           state;
    logic [CNT_W-1:0]     hold_cnt;
    logic                 hold_done;
    logic [CNT_W-1:0]     wd_cnt;
    logic                 wd_timeout;
    logic                 strobe_edge;
    logic                 reset_active;
    logic [CNT_W-1:0]     pull_cnt;
    logic                 pull_meta;
    logic                 pull_seen;
    logic                 ext_edge;

    // A variant without the button sees it as always released
    assign pins_raw = '{
        pushbutton: HAS_PUSHBUTTON ? PUSHBUTTON_RESET_N_IN : 1'h1,
        strobe:     WATCHDOG_STROBE_IN,
        undervolt:  UNDERVOLT_IN
    };

    assign pins_raw_bits = pins_raw;

    // Two flip-flops per pin before any logic reads it
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
        always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
                pins_meta[i] <= PINS_IDLE_BITS[i];
                pins_sync[i] <= PINS_IDLE_BITS[i];
            end else begin
                pins_meta[i] <= pins_raw_bits[i];
                pins_sync[i] <= pins_meta[i];
            end
        end
    end

    assign pins = srw_pins_t'(pins_sync);

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            strobe_prev <= 1'h0;
        end else begin
            strobe_prev <= pins.strobe;
        end
    end

    // Either edge counts as service
    assign strobe_edge = HAS_WATCHDOG && (pins.strobe != strobe_prev);

    // A low must persist for the filter time before it counts: short noise
    // pulses die here, and 1 us stays far inside the 5 us response budget
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pb_cnt <= '0;
        end else if (pins.pushbutton) begin
            pb_cnt <= '0;
        end else if (pb_cnt != PB_LAST) begin
            pb_cnt <= pb_cnt + 1'h1;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pb_pressed <= 1'h0;
        end else if (pins.pushbutton) begin
            pb_pressed <= 1'h0;
        end else if (pb_cnt == PB_LAST) begin
            pb_pressed <= 1'h1;
        end
    end

    // Undervoltage overrides everything; a held button parks the state in
    // PRESS, so the hold time starts only once the button is let go
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state <= SRW_ST_HOLD;
        end else begin
            case (state)
                SRW_ST_HOLD: begin
                    if (pins.undervolt) begin
                        state <= SRW_ST_HOLD;
                    end else if (pb_pressed) begin
                        state <= SRW_ST_PRESS;
                    end else if (hold_done) begin
                        state <= SRW_ST_RUN;
                    end
                end

                SRW_ST_PRESS: begin
                    if (pins.undervolt || !pb_pressed) begin
                        state <= SRW_ST_HOLD;
                    end
                end

                SRW_ST_RUN: begin
                    if (pins.undervolt) begin
                        state <= SRW_ST_HOLD;
                    end else if (pb_pressed) begin
                        state <= SRW_ST_PRESS;
                    end else if (wd_timeout) begin
                        state <= SRW_ST_HOLD;
                    end
                end

                default: begin
                    state <= SRW_ST_HOLD;
                end
            endcase
        end
    end

    assign hold_done = (hold_cnt == HOLD_LAST);

    // Hold time restarts while any cause of reset is still present
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            hold_cnt <= '0;
        end else if (state != SRW_ST_HOLD || pins.undervolt) begin
            hold_cnt <= '0;
        end else if (pb_pressed || hold_done) begin
            hold_cnt <= '0;
        end else begin
            hold_cnt <= hold_cnt + 1'h1;
        end
    end

    // Undervoltage asserts reset directly, not through the state register
    assign reset_active = (state != SRW_ST_RUN) || pins.undervolt;

    // Watchdog runs only while reset is released
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            wd_cnt <= '0;
        end else if (state != SRW_ST_RUN || strobe_edge) begin
            wd_cnt <= '0;
        end else if (wd_cnt != WD_LAST) begin
            wd_cnt <= wd_cnt + 1'b1;
        end
    end

    assign wd_timeout = HAS_WATCHDOG && (wd_cnt == WD_LAST);

    // The pull level goes through the same two flops as the pin, so the
    // synchronised pin can be compared with the pull that it saw
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pull_meta <= 1'h0;
            pull_seen <= 1'h0;
        end else begin
            pull_meta <= WATCHDOG_STROBE_PULL_OUT;
            pull_seen <= pull_meta;
        end
    end

    // An edge against the weak pull can only come from an outside driver
    assign ext_edge = strobe_edge && (pins.strobe != pull_seen);

    // Weak pull pattern runs a full period of its own: low for 7/8, high
    // for the last 1/8. An open pin follows it and so services the timer
    // twice a period; a real driver restarts the pattern with each edge against the pull,
    // which keeps the pull low for as long as the driver is alive.
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pull_cnt <= '0;
        end else if (state != SRW_ST_RUN || ext_edge) begin
            pull_cnt <= '0;
        end else if (pull_cnt == WD_LAST) begin
            pull_cnt <= '0;
        end else begin
            pull_cnt <= pull_cnt + 1'h1;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            WATCHDOG_STROBE_PULL_OUT <= 1'h0;
        end else begin
            WATCHDOG_STROBE_PULL_OUT <= (pull_cnt >= PULL_HIGH);
        end
    end

    assign WATCHDOG_STROBE_PULL_OE_OUT = HAS_WATCHDOG;

    // Both outputs come from flops fed by one level: a reset line must not
    // glitch, and the price is one clock of latency
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RESET_N_OUT <= 1'h0;
            RESET_OUT   <= HAS_RESET_HIGH;
        end else begin
            RESET_N_OUT <= !reset_active;
            RESET_OUT   <= HAS_RESET_HIGH && reset_active;
        end
    end

endmodule : srw_supervisor

// ---- test/srw_processor_model.sv ----
// Processor model: strobes the watchdog pin while it runs normally.
// Assumes it resolves the pin: its own driver wins over the weak pull.
module srw_processor_model #(
    parameter int unsigned GAP = 400
) (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic strobe_en_in,
    input  wire logic float_in,
    input  wire logic pull_in,
    input  wire logic pull_oe_in,
    output logic      pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    logic pin_q = 1'b0;
    always_ff @(posedge clk_in) begin
        if (reset_n_in !== 1'b1 || !strobe_en_in || cnt == GAP - 1) cnt <= 0;
        else cnt <= cnt + 1;
        pin_q <= pin_out;
    end
    // Unpulled open pin wanders, so it never settles at a stable level
    assign pin_out = !float_in ? (cnt >= GAP - 8) : (pull_oe_in ? pull_in : ~pin_q);
endmodule : srw_processor_model

// ---- test/srw_supervisor_assertions.sv ----
// Pin-level timing checks for the supervisory reset block.
// Assumes binding to srw_supervisor with every optional pin present.
module srw_supervisor_checker
    import srw_pkg::*;
#(
    parameter int unsigned HOLD_CNT = HOLD_CYCLES,
    parameter int unsigned WD_CNT   = WD_CYCLES
) (
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic UNDERVOLT_IN,
    input wire logic PUSHBUTTON_RESET_N_IN,
    input wire logic WATCHDOG_STROBE_IN,
    input wire logic WATCHDOG_STROBE_PULL_OUT,
    input wire logic WATCHDOG_STROBE_PULL_OE_OUT,
    input wire logic RESET_N_OUT,
    input wire logic RESET_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HMIN = HOLD_CNT * 7 / 10;
    localparam int unsigned HMAX = 2 * HOLD_CNT + 8;
    localparam int unsigned WMIN = WD_CNT * 7 / 10;
    localparam int unsigned P7   = WD_CNT - WD_CNT / 8;
    int   low_cnt;
    int   q_cnt;
    int   pb_cnt;
    int   wd_cnt;
    logic strobe_q;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // Quiet time excludes any brownout or button activity
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            low_cnt <= 0;
            q_cnt <= 0;
            pb_cnt <= 0;
            wd_cnt <= 0;
            strobe_q <= 1'b0;
        end else begin
            low_cnt <= RESET_N_OUT ? 0 : low_cnt + 1;
            q_cnt <= (UNDERVOLT_IN || !PUSHBUTTON_RESET_N_IN) ? 0 : q_cnt + 1;
            pb_cnt <= PUSHBUTTON_RESET_N_IN ? 0 : pb_cnt + 1;
            wd_cnt <= (!RESET_N_OUT || WATCHDOG_STROBE_IN != strobe_q) ? 0 : wd_cnt + 1;
            strobe_q <= WATCHDOG_STROBE_IN;
        end
    end
    AST_RESET_COMPLEMENT: assert property (RESET_OUT != RESET_N_OUT)
        else $error("reset outputs not complementary");
    AST_UNDERVOLT_RESET: assert property (UNDERVOLT_IN [*4] |-> !RESET_N_OUT)
        else $error("undervoltage without reset");
    AST_BUTTON_DELAY: assert property (pb_cnt == 625 |-> !RESET_N_OUT)
        else $error("button reset too late");
    AST_HOLD_MIN: assert property ($rose(RESET_N_OUT) |-> $past(q_cnt) >= HMIN && $past(low_cnt) >= HMIN)
        else $error("reset released too early");
    AST_HOLD_MAX: assert property (!(!RESET_N_OUT && low_cnt > HMAX && q_cnt > HMAX))
        else $error("reset held too long");
    AST_WD_MAX: assert property (RESET_N_OUT |-> wd_cnt <= WD_CNT + 6)
        else $error("watchdog missed timeout");
    AST_WD_MIN: assert property ($fell(RESET_N_OUT) && q_cnt > 4 |-> $past(wd_cnt) >= WMIN)
        else $error("watchdog timed out early");
    AST_PULL_LATE: assert property ($rose(WATCHDOG_STROBE_PULL_OUT) |-> wd_cnt >= P7 - 2)
        else $error("strobe pull high too early");
    cover property (pb_cnt == 625);
    cover property ($fell(RESET_N_OUT) && q_cnt > 4);
    cover property ($rose(WATCHDOG_STROBE_PULL_OUT));
endmodule : srw_supervisor_checker
bind srw_supervisor srw_supervisor_checker #(.HOLD_CNT(HOLD_CNT), .WD_CNT(WD_CNT)) u_chk (
    .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .UNDERVOLT_IN(UNDERVOLT_IN),
    .PUSHBUTTON_RESET_N_IN(PUSHBUTTON_RESET_N_IN), .WATCHDOG_STROBE_IN(WATCHDOG_STROBE_IN),
    .WATCHDOG_STROBE_PULL_OUT(WATCHDOG_STROBE_PULL_OUT), .RESET_OUT(RESET_OUT),
    .WATCHDOG_STROBE_PULL_OE_OUT(WATCHDOG_STROBE_PULL_OE_OUT), .RESET_N_OUT(RESET_N_OUT));

// ---- test/srw_supervisor_test.sv ----
// Bench for the supervisory reset block: power-up, brownout, button,
// watchdog and open strobe. Assumes shortened hold and period counts.
module srw_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned H = 200;
    localparam int unsigned W = 1600;
    logic ref_clk = 0, rstn = 0, undervolt = 0, pb_n = 1, strobe_en = 1, float_en = 0;
    logic strobe_pin, pull, pull_oe, reset_n, reset_hi;
    int   num_errors = 0, num_checks = 0;
    always #4 ref_clk = ~ref_clk;
    srw_supervisor #(.HOLD_CNT(H), .WD_CNT(W)) DUT (
        .REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .UNDERVOLT_IN(undervolt),
        .PUSHBUTTON_RESET_N_IN(pb_n), .WATCHDOG_STROBE_IN(strobe_pin),
        .WATCHDOG_STROBE_PULL_OUT(pull), .WATCHDOG_STROBE_PULL_OE_OUT(pull_oe),
        .RESET_N_OUT(reset_n), .RESET_OUT(reset_hi));
    srw_processor_model #(.GAP(400)) u_cpu (
        .clk_in(ref_clk), .reset_n_in(reset_n), .strobe_en_in(strobe_en), .float_in(float_en),
        .pull_in(pull), .pull_oe_in(pull_oe), .pin_out(strobe_pin));
    task automatic check(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic wait_rst(input logic v, input int n);
        while (n > 0 && reset_n !== v) begin
            @(negedge ref_clk);
            n--;
        end
        check(reset_n, v);
    endtask : wait_rst
    task automatic expect_release;
        cyc(H * 7 / 10);
        check(reset_n, 1'b0);
        check(reset_hi, 1'b1);
        wait_rst(1'b1, 2 * H);
        check(reset_hi, 1'b0);
    endtask : expect_release
    task automatic brownout;
        @(posedge ref_clk) undervolt <= 1'b1;
        cyc(4);
        check(reset_n, 1'b0);
        @(posedge ref_clk) undervolt <= 1'b0;
        expect_release();
    endtask : brownout
    task automatic button;
        @(posedge ref_clk) pb_n <= 1'b0;
        cyc(11);
        @(posedge ref_clk) pb_n <= 1'b1;
        cyc(700);
        check(reset_n, 1'b1);
        @(posedge ref_clk) pb_n <= 1'b0;
        wait_rst(1'b0, 625);
        cyc(2000);
        check(reset_n, 1'b0);
        @(posedge ref_clk) pb_n <= 1'b1;
        expect_release();
    endtask : button
    task automatic timeout;
        @(posedge ref_clk) strobe_en <= 1'b0;
        repeat (2) begin
            wait_rst(1'b1, 2 * H);
            cyc(W * 7 / 10 - 10);
            check(reset_n, 1'b1);
            wait_rst(1'b0, W);
        end
        @(posedge ref_clk) strobe_en <= 1'b1;
        expect_release();
    endtask : timeout
    task automatic open_strobe;
        int   rises;
        int   highs;
        logic low_seen;
        logic prev;
        rises = 0;
        highs = 0;
        low_seen = 0;
        prev = 1'b1;
        @(posedge ref_clk) float_en <= 1'b1;
        repeat (3 * W) begin
            @(negedge ref_clk);
            low_seen |= (reset_n !== 1'b1);
            rises += int'(pull === 1'b1 && prev !== 1'b1);
            highs += int'(pull === 1'b1);
            prev = pull;
        end
        check(low_seen, 1'b0);
        check(rises >= 3, 1'b1);
        check(highs >= 2 * (W / 8), 1'b1);
        check(pull_oe, 1'b1);
    endtask : open_strobe
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        expect_release();
        cyc(3 * W);
        check(reset_n, 1'b1);
        brownout();
        button();
        timeout();
        open_strobe();
        report_and_stop();
    end
    initial begin
        cyc(60000);
        num_errors++;
        report_and_stop();
    end
endmodule : srw_supervisor_test
